// ---- vgsr_pkg.sv ----
package vgsr_pkg;

    // ------------------------------------------------------------------
    // fixed i/o port addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] OUTCTL_WR_ADDR  = 16'h03c2;
    localparam logic [15:0] STAT0_RD_ADDR   = 16'h03c2;
    localparam logic [15:0] VSE_ADDR        = 16'h03c3;
    localparam logic [15:0] SEQ_INDEX_ADDR  = 16'h03c4;
    localparam logic [15:0] SEQ_DATA_ADDR   = 16'h03c5;
    localparam logic [15:0] FEAT_RD_ADDR    = 16'h03ca;
    localparam logic [15:0] OUTCTL_RD_ADDR  = 16'h03cc;

    // ------------------------------------------------------------------
    // base-relative ports (3?x), upper 12-bit pattern and low nibbles
    // ------------------------------------------------------------------
    localparam logic [11:0] MONO_BASE       = 12'h03b;
    localparam logic [11:0] COLOR_BASE      = 12'h03d;
    localparam logic [3:0]  DTC_INDEX_NIB   = 4'h4;
    localparam logic [3:0]  FEAT_STAT1_NIB  = 4'ha;

    // ------------------------------------------------------------------
    // sequencer indices
    // ------------------------------------------------------------------
    localparam logic [4:0]  SEQ_RESET_IDX   = 5'h00;
    localparam logic [4:0]  SEQ_CLKMODE_IDX = 5'h01;
    localparam logic [4:0]  SEQ_PLANE_IDX   = 5'h02;
    localparam logic [4:0]  SEQ_FONT_IDX    = 5'h03;
    localparam logic [4:0]  SEQ_MEMMODE_IDX = 5'h04;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int OC_COLOR_BIT   = 0;
    localparam int OC_MEMEN_BIT   = 1;
    localparam int OC_CLKSEL_LSB  = 2;
    localparam int OC_PAGE_BIT    = 5;
    localparam int OC_HPOL_BIT    = 6;
    localparam int OC_VPOL_BIT    = 7;
    localparam int FC_VSYNC_OR_BIT = 3;
    localparam int ST0_SENSE_BIT  = 4;
    localparam int ST0_IRQ_BIT    = 7;
    localparam int ST1_NODISP_BIT = 0;
    localparam int ST1_ONE_BIT    = 2;
    localparam int ST1_VRET_BIT   = 3;
    localparam int ST1_FB_LSB     = 4;
    localparam int CM_8DOT_BIT    = 0;
    localparam int CM_LOAD2_BIT   = 2;
    localparam int CM_HALF_BIT    = 3;
    localparam int CM_LOAD4_BIT   = 4;
    localparam int CM_OFF_BIT     = 5;
    localparam int MM_256K_BIT    = 1;
    localparam int MM_SEQ_BIT     = 2;

    // ------------------------------------------------------------------
    // writable-bit masks (reserved bits stay zero)
    // ------------------------------------------------------------------
    localparam logic [7:0] OUTCTL_MASK  = 8'hef;
    localparam logic [7:0] FEAT_MASK    = 8'h08;
    localparam logic [7:0] VSE_MASK     = 8'h01;
    localparam logic [7:0] SEQIDX_MASK  = 8'h1f;
    localparam logic [7:0] SRESET_MASK  = 8'h03;
    localparam logic [7:0] CLKMODE_MASK = 8'h3d;
    localparam logic [7:0] PLANE_MASK   = 8'h0f;
    localparam logic [7:0] FONT_MASK    = 8'h3f;
    localparam logic [7:0] MEMMODE_MASK = 8'h06;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] OUTCTL_RST  = 8'h00;
    localparam logic [7:0] FEAT_RST    = 8'h00;
    localparam logic [7:0] VSE_RST     = 8'h00;
    localparam logic [7:0] SEQIDX_RST  = 8'h00;
    localparam logic [7:0] SRESET_RST  = 8'h00;
    localparam logic [7:0] CLKMODE_RST = 8'h00;
    localparam logic [7:0] PLANE_RST   = 8'h00;
    localparam logic [7:0] FONT_RST    = 8'h00;
    localparam logic [7:0] MEMMODE_RST = 8'h00;
    localparam logic [7:0] DTCIDX_RST  = 8'h00;
    localparam logic [7:0] RDATA_RST   = 8'h00;

endpackage : vgsr_pkg

// ---- vgsr_regs.sv ----
module vgsr_regs
    import vgsr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host i/o port access
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rvalid,
    // display state inputs
    input  wire logic        sense_in,
    input  wire logic        retrace_irq_pending,
    input  wire logic        display_enable_in,
    input  wire logic        vretrace_in,
    input  wire logic [1:0]  color_feedback_in,
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        host_plane_wr,
    // sync outputs
    output logic             hsync_out,
    output logic             vsync_out,
    // control outputs
    output logic             color_base,
    output logic             mem_access_en,
    output logic [1:0]       pixel_dot_clock_sel,
    output logic             pixel_dot_clock_load,
    output logic             high_page_sel,
    output logic             video_enable,
    output logic             char_8dot,
    output logic             serial_load_2,
    output logic             serial_load_4,
    output logic             char_clk_half,
    output logic             screen_blank,
    output logic [3:0]       plane_wr_strobe,
    output logic [2:0]       font_first_sel,
    output logic [2:0]       font_second_sel,
    output logic             mem_256k_en,
    output logic             seq_addr_en,
    output logic [7:0]       display_timing_index
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] output_control_q;
    logic [7:0] feature_control_q;
    logic [7:0] video_subsystem_enable_q;
    logic [7:0] sequencer_index_q;
    logic [7:0] sequencer_reset_q;
    logic [7:0] clocking_mode_q;
    logic [7:0] plane_write_enable_q;
    logic [7:0] font_select_q;
    logic [7:0] memory_mode_q;
    logic [7:0] dtc_index_q;
    logic [7:0] rdata_d;
    logic       hit_dtc_index;
    logic       hit_feat_stat1;
    logic       wr_seq_data;

    // decode of a base-relative port at 3bx or 3dx
    function automatic logic base_hit(input logic [15:0] a,
                                      input logic        color,
                                      input logic [3:0]  nib);
        logic [11:0] base;
        base = color ? COLOR_BASE : MONO_BASE;
        return (a[15:4] == base) && (a[3:0] == nib);
    endfunction : base_hit

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // base ports follow the emulation bit
    assign hit_dtc_index  = base_hit(io_addr, output_control_q[OC_COLOR_BIT],
                                     DTC_INDEX_NIB);
    assign hit_feat_stat1 = base_hit(io_addr, output_control_q[OC_COLOR_BIT],
                                     FEAT_STAT1_NIB);
    assign wr_seq_data    = io_wr && (io_addr == SEQ_DATA_ADDR);

    // ------------------------------------------------------------------
    // general registers
    // ------------------------------------------------------------------
    // output control write path
    always_ff @(posedge clk) begin
        if (rst) begin
            output_control_q <= OUTCTL_RST;
        end else if (io_wr && io_addr == OUTCTL_WR_ADDR) begin
            output_control_q <= io_wdata & OUTCTL_MASK;
        end
    end

    // dot clock pll load pulse on every output control write
    always_ff @(posedge clk) begin
        if (rst) begin
            pixel_dot_clock_load <= 1'b0;
        end else begin
            pixel_dot_clock_load <= io_wr && io_addr == OUTCTL_WR_ADDR;
        end
    end

    // feature control, written at 3?a
    always_ff @(posedge clk) begin
        if (rst) begin
            feature_control_q <= FEAT_RST;
        end else if (io_wr && hit_feat_stat1) begin
            feature_control_q <= io_wdata & FEAT_MASK;
        end
    end

    // video subsystem enable
    always_ff @(posedge clk) begin
        if (rst) begin
            video_subsystem_enable_q <= VSE_RST;
        end else if (io_wr && io_addr == VSE_ADDR) begin
            video_subsystem_enable_q <= io_wdata & VSE_MASK;
        end
    end

    // timing controller index at 3?4
    always_ff @(posedge clk) begin
        if (rst) begin
            dtc_index_q <= DTCIDX_RST;
        end else if (io_wr && hit_dtc_index) begin
            dtc_index_q <= io_wdata;
        end
    end

    // ------------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------------
    // sequencer index
    always_ff @(posedge clk) begin
        if (rst) begin
            sequencer_index_q <= SEQIDX_RST;
        end else if (io_wr && io_addr == SEQ_INDEX_ADDR) begin
            sequencer_index_q <= io_wdata & SEQIDX_MASK;
        end
    end

    // indexed data writes; unknown indices are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            sequencer_reset_q    <= SRESET_RST;
            clocking_mode_q      <= CLKMODE_RST;
            plane_write_enable_q <= PLANE_RST;
            font_select_q        <= FONT_RST;
            memory_mode_q        <= MEMMODE_RST;
        end else if (wr_seq_data) begin
            case (sequencer_index_q[4:0])
                SEQ_RESET_IDX:   sequencer_reset_q <= io_wdata & SRESET_MASK;
                SEQ_CLKMODE_IDX: clocking_mode_q <= io_wdata & CLKMODE_MASK;
                SEQ_PLANE_IDX:   plane_write_enable_q <= io_wdata & PLANE_MASK;
                SEQ_FONT_IDX:    font_select_q <= io_wdata & FONT_MASK;
                SEQ_MEMMODE_IDX: memory_mode_q <= io_wdata & MEMMODE_MASK;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // read mux, unmapped ports read zero
    always_comb begin
        rdata_d = 8'h00;
        if (io_addr == STAT0_RD_ADDR) begin
            rdata_d[ST0_SENSE_BIT] = sense_in;
            rdata_d[ST0_IRQ_BIT]   = retrace_irq_pending;
        end else if (io_addr == OUTCTL_RD_ADDR) begin
            rdata_d = output_control_q;
        end else if (io_addr == FEAT_RD_ADDR) begin
            rdata_d = feature_control_q;
        end else if (io_addr == VSE_ADDR) begin
            rdata_d = video_subsystem_enable_q;
        end else if (io_addr == SEQ_INDEX_ADDR) begin
            rdata_d = sequencer_index_q;
        end else if (io_addr == SEQ_DATA_ADDR) begin
            case (sequencer_index_q[4:0])
                SEQ_RESET_IDX:   rdata_d = sequencer_reset_q;
                SEQ_CLKMODE_IDX: rdata_d = clocking_mode_q;
                SEQ_PLANE_IDX:   rdata_d = plane_write_enable_q;
                SEQ_FONT_IDX:    rdata_d = font_select_q;
                SEQ_MEMMODE_IDX: rdata_d = memory_mode_q;
                default:         rdata_d = 8'h00;
            endcase
        end else if (hit_feat_stat1) begin
            rdata_d[ST1_NODISP_BIT] = ~display_enable_in;
            rdata_d[ST1_ONE_BIT]    = 1'b1;
            rdata_d[ST1_VRET_BIT]   = vretrace_in;
            rdata_d[ST1_FB_LSB+:2]  = color_feedback_in;
        end else if (hit_dtc_index) begin
            rdata_d = dtc_index_q;
        end
    end

    // read data registered, valid one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata  <= RDATA_RST;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd;
            if (io_rd) begin
                io_rdata <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // sync outputs
    // ------------------------------------------------------------------
    // polarity and display-enable merge
    always_ff @(posedge clk) begin
        if (rst) begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
        end else begin
            hsync_out <= hsync_in ^ output_control_q[OC_HPOL_BIT];
            vsync_out <= (vsync_in | (feature_control_q[FC_VSYNC_OR_BIT]
                          & display_enable_in))
                         ^ output_control_q[OC_VPOL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    // registered copies of control fields
    always_ff @(posedge clk) begin
        if (rst) begin
            color_base           <= 1'b0;
            mem_access_en        <= 1'b0;
            pixel_dot_clock_sel  <= 2'h0;
            high_page_sel        <= 1'b0;
            video_enable         <= 1'b0;
            char_8dot            <= 1'b0;
            serial_load_2        <= 1'b0;
            serial_load_4        <= 1'b0;
            char_clk_half        <= 1'b0;
            screen_blank         <= 1'b0;
            font_first_sel       <= 3'h0;
            font_second_sel      <= 3'h0;
            mem_256k_en          <= 1'b0;
            seq_addr_en          <= 1'b0;
            display_timing_index <= 8'h00;
        end else begin
            color_base          <= output_control_q[OC_COLOR_BIT];
            mem_access_en       <= output_control_q[OC_MEMEN_BIT];
            pixel_dot_clock_sel <= output_control_q[OC_CLKSEL_LSB+:2];
            high_page_sel       <= output_control_q[OC_PAGE_BIT];
            video_enable        <= video_subsystem_enable_q[0];
            char_8dot           <= clocking_mode_q[CM_8DOT_BIT];
            serial_load_2       <= clocking_mode_q[CM_LOAD2_BIT];
            serial_load_4       <= clocking_mode_q[CM_LOAD4_BIT];
            char_clk_half       <= clocking_mode_q[CM_HALF_BIT];
            screen_blank        <= clocking_mode_q[CM_OFF_BIT];
            font_first_sel      <= {font_select_q[4],
                                    font_select_q[1:0]};
            font_second_sel     <= {font_select_q[5],
                                    font_select_q[3:2]};
            mem_256k_en         <= memory_mode_q[MM_256K_BIT];
            seq_addr_en         <= memory_mode_q[MM_SEQ_BIT];
            display_timing_index <= dtc_index_q;
        end
    end

    // per-plane write strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            plane_wr_strobe <= 4'h0;
        end else begin
            plane_wr_strobe <= {4{host_plane_wr}}
                               & plane_write_enable_q[3:0];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_outctl_readback: assert property (@(posedge clk) disable iff (rst)
        io_wr && io_addr == OUTCTL_WR_ADDR ##1 !io_wr ##1 io_rd && !io_wr
            && io_addr == OUTCTL_RD_ADDR
        |=> io_rvalid && io_rdata == ($past(io_wdata, 3) & OUTCTL_MASK))
        else $error("output control readback mismatch");
    a_base_select: assert property (@(posedge clk) disable iff (rst)
        io_wr && io_addr == OUTCTL_WR_ADDR
        |=> ##1 color_base == $past(io_wdata[OC_COLOR_BIT], 2))
        else $error("emulation base not following write");
    a_pll_load_pulse: assert property (@(posedge clk) disable iff (rst)
        io_wr && io_addr == OUTCTL_WR_ADDR |=> pixel_dot_clock_load)
        else $error("dot clock load pulse missing");
    a_hsync_polarity: assert property (@(posedge clk) disable iff (rst)
        $stable(output_control_q) |=> hsync_out == ($past(hsync_in)
            ^ $past(output_control_q[OC_HPOL_BIT])))
        else $error("hsync polarity wrong");
    a_status1_fixed: assert property (@(posedge clk) disable iff (rst)
        io_rd && hit_feat_stat1 && !io_wr
        |=> io_rdata[ST1_ONE_BIT] && io_rdata[7:6] == 2'b00)
        else $error("status 1 fixed bits wrong");
    a_status0_sense: assert property (@(posedge clk) disable iff (rst)
        io_rd && io_addr == STAT0_RD_ADDR
        |=> io_rdata[ST0_SENSE_BIT] == $past(sense_in)
            && io_rdata[3:0] == 4'h0)
        else $error("status 0 sense bit wrong");
    a_index_width: assert property (@(posedge clk) disable iff (rst)
        io_wr && io_addr == SEQ_INDEX_ADDR
        |=> sequencer_index_q == ($past(io_wdata) & SEQIDX_MASK))
        else $error("sequencer index not five bits");
    a_plane_gate: assert property (@(posedge clk) disable iff (rst)
        !host_plane_wr |=> plane_wr_strobe == 4'h0)
        else $error("plane strobe without host write");
    a_blank_follow: assert property (@(posedge clk) disable iff (rst)
        wr_seq_data && sequencer_index_q[4:0] == SEQ_CLKMODE_IDX
        |=> ##1 screen_blank == $past(io_wdata[CM_OFF_BIT], 2))
        else $error("screen blank not following write");
    a_font_compose: assert property (@(posedge clk) disable iff (rst)
        $stable(font_select_q) |=> font_second_sel
            == {$past(font_select_q[5]), $past(font_select_q[3:2])})
        else $error("second font select wrong");

endmodule : vgsr_regs

// ---- vgsr_host_model.sv ----
module vgsr_host_model (
    // clock
    input  wire logic        clk,
    // host i/o port
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] exp_q[$];  // expected read data, oldest first

    // bus idle at time zero
    initial begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // one write strobe; released lines move off the last value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(posedge clk);
        #1;
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask : wr

    // one read strobe; the expected byte is noted for the monitor
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        #1;
        io_addr = a;
        io_rd   = 1'b1;
        @(posedge clk);
        #1;
        io_rd   = 1'b0;
        io_addr = ~a;
    endtask : rd

    // index always goes out before the data port
    task automatic seq_wr(input logic [4:0] idx, input logic [7:0] d);
        wr(16'h03c4, {3'h0, idx});
        wr(16'h03c5, d);
    endtask : seq_wr
endmodule : vgsr_host_model

// ---- vga_general_sequencer_regs_tb.sv ----
module vga_general_sequencer_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vgsr_pkg::*;

    logic clk, rst, io_wr, io_rd, io_rvalid, sense_in, retrace_irq_pending;
    logic display_enable_in, vretrace_in, hsync_in, vsync_in, host_plane_wr;
    logic hsync_out, vsync_out, color_base, mem_access_en, high_page_sel;
    logic pixel_dot_clock_load, video_enable, char_8dot, serial_load_2;
    logic serial_load_4, char_clk_half, screen_blank, mem_256k_en, seq_addr_en;
    logic [15:0] io_addr, b, o;
    logic [7:0]  io_wdata, io_rdata, display_timing_index, v, f, t, d;
    logic [1:0]  color_feedback_in, pixel_dot_clock_sel;
    logic [3:0]  plane_wr_strobe;
    logic [2:0]  font_first_sel, font_second_sel;
    logic [7:0]  sv[5];
    logic [7:0]  m[5] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h06};
    logic [31:0] seed = 32'h9781;
    int          error_cnt = 0;
    int          check_count = 0;

    vgsr_regs DUT (
        .clk(clk), .rst(rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .sense_in(sense_in), .retrace_irq_pending(retrace_irq_pending),
        .display_enable_in(display_enable_in), .vretrace_in(vretrace_in),
        .color_feedback_in(color_feedback_in), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .host_plane_wr(host_plane_wr),
        .hsync_out(hsync_out), .vsync_out(vsync_out),
        .color_base(color_base), .mem_access_en(mem_access_en),
        .pixel_dot_clock_sel(pixel_dot_clock_sel),
        .pixel_dot_clock_load(pixel_dot_clock_load),
        .high_page_sel(high_page_sel), .video_enable(video_enable),
        .char_8dot(char_8dot), .serial_load_2(serial_load_2),
        .serial_load_4(serial_load_4), .char_clk_half(char_clk_half),
        .screen_blank(screen_blank), .plane_wr_strobe(plane_wr_strobe),
        .font_first_sel(font_first_sel), .font_second_sel(font_second_sel),
        .mem_256k_en(mem_256k_en), .seq_addr_en(seq_addr_en),
        .display_timing_index(display_timing_index)
    );
    vgsr_host_model host (
        .clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata)
    );

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // each answered read takes the oldest note
    always @(negedge clk) begin
        if (io_rvalid === 1'b1) begin
            if (host.exp_q.size() == 0) begin
                error_cnt++;
                $display("BAD read unexpected seen %h", io_rdata);
            end else begin
                check("read", io_rdata, host.exp_q.pop_front());
            end
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        host_plane_wr = 1'b0;
        {sense_in, retrace_irq_pending, display_enable_in} = 3'(rnd());
        {vretrace_in, hsync_in, vsync_in} = 3'(rnd());
        color_feedback_in = 2'(rnd());
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        host.rd(16'h03cc, 8'h00);
        host.rd(16'h03c2, {retrace_irq_pending, 2'b00, sense_in, 4'h0});
        // both bases: right base answers, the other one is ignored
        for (int p = 0; p < 2; p++) begin
            v = (rnd() & 8'hfe) | 8'(p);
            f = rnd();
            t = rnd();
            b = p ? 16'h03d0 : 16'h03b0;
            o = b ^ 16'h0060;
            host.wr(16'h03c2, v);
            check("pll_load", pixel_dot_clock_load, 1'b1);
            host.rd(16'h03cc, v & 8'hef);
            host.wr(b | 16'h000a, f);
            host.wr(o | 16'h000a, ~f);
            host.wr(b | 16'h0004, t);
            host.wr(o | 16'h0004, ~t);
            host.rd(16'h03ca, f & 8'h08);
            host.rd(b | 16'h000a, {2'b00, color_feedback_in, vretrace_in,
                                   1'b1, 1'b0, ~display_enable_in});
            host.rd(o | 16'h000a, 8'h00);
            host.rd(b | 16'h0004, t);
            check("color_base", color_base, v[0]);
            check("mem_access", mem_access_en, v[1]);
            check("clk_sel", pixel_dot_clock_sel, v[3:2]);
            check("high_page", high_page_sel, v[5]);
            check("hsync", hsync_out, hsync_in ^ v[6]);
            check("vsync", vsync_out, (vsync_in | (f[3] & display_enable_in))
                  ^ v[7]);
            check("dtc_index", display_timing_index, t);
        end
        // sequencer registers through the index/data pair, plus one past
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            host.seq_wr(5'(i), d);
            if (i < 5) sv[i] = d & m[i];
            host.rd(16'h03c4, 8'(i));
            host.rd(16'h03c5, (i < 5) ? (d & m[i]) : 8'h00);
        end
        // reset bits only stored: other sequencer fields survive
        host.seq_wr(5'h00, 8'hff);
        host.rd(16'h03c5, 8'h03);
        check("char_8dot", char_8dot, sv[1][0]);
        check("load_2", serial_load_2, sv[1][2]);
        check("load_4", serial_load_4, sv[1][4]);
        check("half_clk", char_clk_half, sv[1][3]);
        check("blank", screen_blank, sv[1][5]);
        check("font_1", font_first_sel, {sv[3][4], sv[3][1:0]});
        check("font_2", font_second_sel, {sv[3][5], sv[3][3:2]});
        check("mem_256k", mem_256k_en, sv[4][1]);
        check("seq_addr", seq_addr_en, sv[4][2]);
        // one host memory write pulse, gated per plane
        @(posedge clk);
        #1;
        host_plane_wr = 1'b1;
        @(posedge clk);
        #1;
        host_plane_wr = 1'b0;
        check("planes", plane_wr_strobe, sv[2][3:0]);
        @(posedge clk);
        #1;
        check("planes_idle", plane_wr_strobe, 4'h0);
        host.wr(16'h03c4, 8'hff);
        host.rd(16'h03c4, 8'h1f);
        host.wr(16'h03c3, 8'hff);
        host.rd(16'h03c3, 8'h01);
        host.rd(16'h03c0, 8'h00);
        check("video_en", video_enable, 1'b1);
        // mid-run reset returns every register to zero
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check("reset_base", color_base, 1'b0);
        host.rd(16'h03cc, 8'h00);
        host.rd(16'h03b4, 8'h00);
        // bounded drain of outstanding reads
        for (int k = 0; k < 20 && host.exp_q.size() != 0; k++) @(posedge clk);
        if (host.exp_q.size() != 0) begin
            error_cnt++;
            $display("BAD read_count expected 0 seen %0d", host.exp_q.size());
        end
        results();
    end
endmodule : vga_general_sequencer_regs_tb
